/* File: hdl/can_node_config_objects.sv */
// The Avalon-MM slave port was chosen for this implementation.
`include "can_cfg_consts.svh"

module can_node_config_objects (
    input wire logic mclk,
    input wire logic reset,
    input can_cfg_pkg::av_req_s av_req,
    output can_cfg_pkg::av_rsp_s av_rsp,
    output logic [7:0] bit_rate_code,
    output logic [15:0] bit_rate_kbps,
    output logic [7:0] node_identifier,
    output logic store_busy,
    output logic config_pending
);

    // ****************************************************
    // Decoding helpers
    // ****************************************************

    // Legal bit-rate code
    function automatic logic rate_ok(input logic [7:0] code);
        rate_ok = (code <= `CFG_RATE_MAX);
    endfunction

    // Legal node identifier
    function automatic logic node_ok(input logic [7:0] id);
        node_ok = (id >= `CFG_NODE_MIN) && (id <= `CFG_NODE_MAX);
    endfunction

    // Code to kbit/s; illegal codes never reach here but read zero
    function automatic logic [15:0] rate_kbps(input logic [7:0] code);
        case (code)
            8'h00: rate_kbps = `CFG_KBPS_0;
            8'h01: rate_kbps = `CFG_KBPS_1;
            8'h02: rate_kbps = `CFG_KBPS_2;
            8'h03: rate_kbps = `CFG_KBPS_3;
            8'h04: rate_kbps = `CFG_KBPS_4;
            8'h05: rate_kbps = `CFG_KBPS_5;
            8'h06: rate_kbps = `CFG_KBPS_6;
            8'h07: rate_kbps = `CFG_KBPS_7;
            8'h08: rate_kbps = `CFG_KBPS_8;
            default: rate_kbps = 16'h0000;
        endcase
    endfunction

    // ****************************************************
    // State and the non-volatile image
    // ****************************************************

    can_cfg_pkg::cfg_state_s s_q;
    can_cfg_pkg::cfg_state_s s_d;
    logic [7:0] stored_rate;
    logic [7:0] stored_node;
    logic nv_busy;
    logic pending;
    logic [31:0] status_word;
    logic [31:0] read_word;

    // Programming model of the configuration memory
    cfg_nv_store u_nv (
        .mclk(mclk),
        .reset(reset),
        .store_req(s_q.store_req),
        .rate_in(s_q.rate),
        .node_in(s_q.node),
        .stored_rate(stored_rate),
        .stored_node(stored_node),
        .busy(nv_busy)
    );

    // Something written has not yet reached the running node
    assign pending = (s_q.rate != s_q.act_rate) ||
                     (s_q.node != s_q.act_node) ||
                     (stored_rate != s_q.act_rate) ||
                     (stored_node != s_q.act_node);

    // ****************************************************
    // Read path
    // ****************************************************

    // Status word: running values, store busy, pending, sticky refusals
    always_comb begin
        status_word = 32'h00000000;
        status_word[`CFG_STAT_RATE_LSB +: 8] = s_q.act_rate;
        status_word[`CFG_STAT_NODE_LSB +: 8] = s_q.act_node;
        status_word[`CFG_STAT_BUSY] = nv_busy;
        status_word[`CFG_STAT_PEND] = pending;
        status_word[`CFG_STAT_REJ_RO] = s_q.rej_ro;
        status_word[`CFG_STAT_REJ_RANGE] = s_q.rej_range;
    end

    // Read multiplexer; unmapped indices read as zero
    always_comb begin
        read_word = 32'h00000000;
        case (av_req.address)
            `CFG_IDX_TX2_MAP: read_word = `CFG_TX2_MAP_VAL;
            `CFG_IDX_RATE: read_word = {24'h000000, s_q.rate};
            `CFG_IDX_NODE: read_word = {24'h000000, s_q.node};
            `CFG_IDX_STAT: read_word = status_word;
            default: read_word = 32'h00000000;
        endcase
    end

    // ****************************************************
    // Bus handshake and object updates
    // ****************************************************

    // One wait cycle per access: read data are registered on the way
    // into the answer cycle so they stand still at the sampling edge.
    // Writes act in the answer cycle, when the master still holds them.
    always_comb begin
        s_d = s_q;
        s_d.store_req = 1'b0;
        unique case (s_q.fsm)
            can_cfg_pkg::BUS_IDLE: begin
                if (av_req.read || av_req.write) begin
                    s_d.fsm = can_cfg_pkg::BUS_ACK;
                    s_d.readdata = av_req.read ? read_word : 32'h00000000;
                end
            end
            can_cfg_pkg::BUS_ACK: begin
                s_d.fsm = can_cfg_pkg::BUS_IDLE;
                // Clear first so that a refusal in this cycle wins
                if (av_req.write && av_req.byteenable[2] &&
                    av_req.address == `CFG_IDX_STAT) begin
                    if (av_req.writedata[`CFG_STAT_REJ_RO]) begin
                        s_d.rej_ro = 1'b0;
                    end
                    if (av_req.writedata[`CFG_STAT_REJ_RANGE]) begin
                        s_d.rej_range = 1'b0;
                    end
                end
                if (av_req.write) begin
                    case (av_req.address)
                        `CFG_IDX_TX2_MAP: begin
                            s_d.rej_ro = 1'b1;
                        end
                        `CFG_IDX_RATE: begin
                            if (av_req.byteenable[0]) begin
                                if (rate_ok(av_req.writedata[7:0])) begin
                                    s_d.rate = av_req.writedata[7:0];
                                end else begin
                                    s_d.rej_range = 1'b1;
                                end
                            end
                        end
                        `CFG_IDX_NODE: begin
                            if (av_req.byteenable[0]) begin
                                if (node_ok(av_req.writedata[7:0])) begin
                                    s_d.node = av_req.writedata[7:0];
                                end else begin
                                    s_d.rej_range = 1'b1;
                                end
                            end
                        end
                        `CFG_IDX_CTRL: begin
                            // Commands are dropped while programming runs
                            if (av_req.byteenable[0] && !nv_busy) begin
                                if (av_req.writedata[`CFG_CTRL_STORE]) begin
                                    s_d.store_req = 1'b1;
                                end else if (av_req.writedata[
                                        `CFG_CTRL_REINIT]) begin
                                    s_d.rate = stored_rate;
                                    s_d.node = stored_node;
                                    s_d.act_rate = stored_rate;
                                    s_d.act_node = stored_node;
                                    s_d.act_kbps = rate_kbps(stored_rate);
                                end
                            end
                        end
                        default: begin
                            s_d.fsm = can_cfg_pkg::BUS_IDLE;
                        end
                    endcase
                end
            end
            default: begin
                s_d.fsm = can_cfg_pkg::BUS_IDLE;
            end
        endcase
    end

    // ****************************************************
    // State register
    // ****************************************************

    always_ff @(posedge mclk) begin
        if (reset) begin
            s_q <= '{fsm: can_cfg_pkg::BUS_IDLE,
                     readdata: 32'h00000000,
                     rate: `CFG_RATE_RST,
                     node: `CFG_NODE_RST,
                     act_rate: `CFG_RATE_RST,
                     act_node: `CFG_NODE_RST,
                     act_kbps: `CFG_KBPS_2,
                     rej_ro: 1'b0,
                     rej_range: 1'b0,
                     store_req: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************
    // Outputs
    // ****************************************************

    // Waitrequest drops only in the answer cycle
    assign av_rsp.waitrequest = (s_q.fsm != can_cfg_pkg::BUS_ACK);
    assign av_rsp.readdata = s_q.readdata;

    // Running values, changed only by reinit
    assign bit_rate_code = s_q.act_rate;
    assign bit_rate_kbps = s_q.act_kbps;
    assign node_identifier = s_q.act_node;
    assign store_busy = nv_busy;
    assign config_pending = pending;

endmodule

/* File: include/can_cfg_consts.svh */
// Operation
// - Second transmit message mapping reads 60040020h, ignores writes.
// - Mapping entries stay read-only; a master write to one is refused.
// - Rate codes 0..8 give 10,20,50,100,125,250,500,800,1000 kbit/s.
// - The bit-rate selector is 8-bit read/write and resets to code 2.
// - The node identifier only accepts values 1 through 127.
// - The node identifier is 8-bit read/write and resets to 1.
`ifndef CAN_CFG_CONSTS_SVH
`define CAN_CFG_CONSTS_SVH

// ****************************************************
// Object indices (byte address is four times these)
// ****************************************************
`define CFG_IDX_TX2_MAP 16'h1a01
`define CFG_IDX_RATE 16'h2100
`define CFG_IDX_NODE 16'h2101
`define CFG_IDX_CTRL 16'h2180
`define CFG_IDX_STAT 16'h2181

// ****************************************************
// Reset values and limits
// ****************************************************
`define CFG_TX2_MAP_VAL 32'h60040020
`define CFG_RATE_RST 8'h02
`define CFG_NODE_RST 8'h01
`define CFG_RATE_MAX 8'h08
`define CFG_NODE_MIN 8'h01
`define CFG_NODE_MAX 8'h7f

// ****************************************************
// Control and status fields
// ****************************************************
`define CFG_CTRL_STORE 0
`define CFG_CTRL_REINIT 1
`define CFG_STAT_RATE_LSB 0
`define CFG_STAT_NODE_LSB 8
`define CFG_STAT_BUSY 16
`define CFG_STAT_PEND 17
`define CFG_STAT_REJ_RO 18
`define CFG_STAT_REJ_RANGE 19

// ****************************************************
// Bit rate table in kbit/s
// ****************************************************
`define CFG_KBPS_0 16'h000a
`define CFG_KBPS_1 16'h0014
`define CFG_KBPS_2 16'h0032
`define CFG_KBPS_3 16'h0064
`define CFG_KBPS_4 16'h007d
`define CFG_KBPS_5 16'h00fa
`define CFG_KBPS_6 16'h01f4
`define CFG_KBPS_7 16'h0320
`define CFG_KBPS_8 16'h03e8

// ****************************************************
// Timing
// ****************************************************
`define CFG_CLK_NS 5
`define CFG_STORE_NS 1000

`endif

/* File: include/can_cfg_pkg.sv */
package can_cfg_pkg;

    // Bus handshake states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_e;

    // Avalon-MM request from the master
    typedef struct packed {
        logic [15:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } av_req_s;

    // Avalon-MM answer to the master
    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } av_rsp_s;

    // Whole state of the object block
    typedef struct packed {
        bus_state_e fsm;
        logic [31:0] readdata;
        logic [7:0] rate;
        logic [7:0] node;
        logic [7:0] act_rate;
        logic [7:0] act_node;
        logic [15:0] act_kbps;
        logic rej_ro;
        logic rej_range;
        logic store_req;
    } cfg_state_s;

    // Whole state of the non-volatile image
    typedef struct packed {
        logic [7:0] cnt;
        logic busy;
        logic [7:0] new_rate;
        logic [7:0] new_node;
        logic [7:0] rate;
        logic [7:0] node;
    } nv_state_s;

endpackage

/* File: hdl/cfg_nv_store.sv */
`include "can_cfg_consts.svh"

module cfg_nv_store (
    input wire logic mclk,
    input wire logic reset,
    input wire logic store_req,
    input wire logic [7:0] rate_in,
    input wire logic [7:0] node_in,
    output logic [7:0] stored_rate,
    output logic [7:0] stored_node,
    output logic busy
);

    // Programming time as whole cycles, rounded up
    localparam logic [7:0] STORE_CYCLES =
        8'((`CFG_STORE_NS + `CFG_CLK_NS - 1) / `CFG_CLK_NS);

    can_cfg_pkg::nv_state_s s_q;
    can_cfg_pkg::nv_state_s s_d;

    // Image is only committed at the end of the write time, so stored_rate and
    // stored_node keep the old, complete image; reinit is dropped during programming
    always_comb begin
        s_d = s_q;
        if (s_q.busy) begin
            if (s_q.cnt == 8'h00) begin
                s_d.busy = 1'b0;
                s_d.rate = s_q.new_rate;
                s_d.node = s_q.new_node;
            end else begin
                s_d.cnt = s_q.cnt - 8'h01;
            end
        end else if (store_req) begin
            s_d.busy = 1'b1;
            s_d.cnt = STORE_CYCLES - 8'h01;
            s_d.new_rate = rate_in;
            s_d.new_node = node_in;
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_q <= '{cnt: 8'h00, busy: 1'b0,
                     new_rate: `CFG_RATE_RST, new_node: `CFG_NODE_RST,
                     rate: `CFG_RATE_RST, node: `CFG_NODE_RST};
        end else begin
            s_q <= s_d;
        end
    end

    assign stored_rate = s_q.rate;
    assign stored_node = s_q.node;
    assign busy = s_q.busy;

endmodule

/* File: testbench/can_cfg_properties.sv */
module can_cfg_properties (
    input wire logic mclk,
    input wire logic reset,
    input can_cfg_pkg::av_req_s av_req,
    input can_cfg_pkg::av_rsp_s av_rsp,
    input wire logic [7:0] bit_rate_code,
    input wire logic [15:0] bit_rate_kbps,
    input wire logic [7:0] node_identifier,
    input wire logic store_busy,
    input wire logic config_pending
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Object block properties
    // ****************************************
    // Write accepted at its answer edge
    logic wr_ok;
    logic bad_val;
    logic [15:0] tab [9] = '{16'h000a, 16'h0014, 16'h0032, 16'h0064,
        16'h007d, 16'h00fa, 16'h01f4, 16'h0320, 16'h03e8};
    assign wr_ok = av_req.write && !av_rsp.waitrequest && av_req.byteenable[0];
    // Out-of-range values that must leave state alone
    assign bad_val = (av_req.address == 16'h2100 &&
        av_req.writedata[7:0] > 8'h08) || (av_req.address == 16'h2101 &&
        (av_req.writedata[7:0] == 8'h00 || av_req.writedata[7]));
    sequence s_quiet;
        !config_pending [*2];
    endsequence
    sequence s_prog;
        ##[1:3] store_busy ##1 store_busy [*8];
    endsequence
    property p_map_read;
        @(posedge mclk) disable iff (reset)
        av_req.read && !av_rsp.waitrequest && av_req.address == 16'h1a01
            |-> av_rsp.readdata == 32'h60040020;
    endproperty
    a_map_read: assert property (p_map_read) else $error("map read");
    property p_map_write;
        @(posedge mclk) disable iff (reset)
        wr_ok && av_req.address == 16'h1a01 && !config_pending && !store_busy
            |=> s_quiet;
    endproperty
    a_map_write: assert property (p_map_write) else $error("map wr");
    property p_table;
        @(posedge mclk) disable iff (reset)
        bit_rate_code <= 8'h08 && bit_rate_kbps == tab[bit_rate_code[3:0]];
    endproperty
    a_table: assert property (p_table) else $error("rate table");
    property p_rst;
        @(posedge mclk)
        reset |=> bit_rate_code == 8'h02 && node_identifier == 8'h01 && !store_busy;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values");
    property p_node;
        @(posedge mclk) disable iff (reset)
        node_identifier != 8'h00 && !node_identifier[7];
    endproperty
    a_node: assert property (p_node) else $error("node range");
    property p_range;
        @(posedge mclk) disable iff (reset)
        wr_ok && bad_val && !config_pending && !store_busy |=> s_quiet;
    endproperty
    a_range: assert property (p_range) else $error("range kept");
    property p_hold;
        @(posedge mclk) disable iff (reset)
        !$past(reset) && $changed(bit_rate_code)
            |-> $past(wr_ok && av_req.address == 16'h2180);
    endproperty
    a_hold: assert property (p_hold) else $error("rate changed");
    property p_prog;
        @(posedge mclk) disable iff (reset)
        wr_ok && av_req.address == 16'h2180 && av_req.writedata[0] &&
            !store_busy |-> s_prog;
    endproperty
    a_prog: assert property (p_prog) else $error("store busy");
endmodule

/* File: testbench/cfg_bus_master.sv */
module cfg_bus_master (
    input wire logic mclk,
    output can_cfg_pkg::av_req_s av_req,
    input can_cfg_pkg::av_rsp_s av_rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Bus master model
    // ****************************************
    initial av_req = '0;
    // callers pass legal values except in refusal cases
    // Released lines show the inverse, so stale data never looks valid
    task automatic acc(input logic wr, input logic [15:0] a,
            input logic [31:0] d, output logic [31:0] q, output bit late);
        int n;
        late = 1'b1;
        q = '0;
        @(posedge mclk);
        av_req.address <= a;
        av_req.writedata <= d;
        av_req.byteenable <= 4'hf;
        av_req.write <= wr;
        av_req.read <= !wr;
        for (n = 0; n < 50 && late; n++) begin
            @(posedge mclk);
            if (av_rsp.waitrequest === 1'b0) begin
                q = av_rsp.readdata;
                late = 1'b0;
            end
        end
        av_req.read <= 1'b0;
        av_req.write <= 1'b0;
        av_req.address <= ~a;
        av_req.writedata <= ~d;
    endtask
endmodule

/* File: testbench/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    can_cfg_pkg::av_req_s av_req;
    can_cfg_pkg::av_rsp_s av_rsp;
    logic [7:0] bit_rate_code, node_identifier;
    logic [15:0] bit_rate_kbps;
    logic store_busy, config_pending;
    int bad_count = 0;
    int n_compared = 0;
    int i;
    bit late;
    logic [31:0] s = 32'h000149c2;
    logic [31:0] q, c, w_rate, w_node, s_rate, s_node, r_rate, r_node;
    // A refusal comes first in each array, while nothing is pending yet
    logic [31:0] rb [4] = '{32'h9, 32'h8, 32'h0, 32'hff};
    logic [31:0] nb [4] = '{32'h80, 32'h7f, 32'h0, 32'h1};
    logic [15:0] tab [9] = '{16'h000a, 16'h0014, 16'h0032, 16'h0064,
        16'h007d, 16'h00fa, 16'h01f4, 16'h0320, 16'h03e8};
    // ****************************************
    // Design, master and clock
    // ****************************************
    can_node_config_objects dut (.mclk(mclk), .reset(reset),
        .av_req(av_req), .av_rsp(av_rsp), .bit_rate_code(bit_rate_code),
        .bit_rate_kbps(bit_rate_kbps), .node_identifier(node_identifier),
        .store_busy(store_busy), .config_pending(config_pending));
    cfg_bus_master m (.mclk(mclk), .av_req(av_req), .av_rsp(av_rsp));
    always #2.5 mclk = ~mclk;
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // A bus access that never answers ends the run
    task automatic rw(input logic wr, input logic [15:0] a,
            input logic [31:0] d);
        m.acc(wr, a, d, q, late);
        if (late) begin
            bad_count++;
            test_done();
        end
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        for (n = 0; n < lim && store_busy !== lvl; n++) @(posedge mclk);
        if (store_busy !== lvl) begin
            bad_count++;
            test_done();
        end
    endtask
    // Reset clears the model and checks the running outputs
    task automatic do_reset();
        reset <= 1'b1;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        {w_rate, s_rate, r_rate} = {3{32'h2}};
        {w_node, s_node, r_node} = {3{32'h1}};
        chk(bit_rate_code, 32'h2);
        chk(bit_rate_kbps, 32'h32);
        chk(node_identifier, 32'h1);
        chk(store_busy, 32'h0);
        chk(config_pending, 32'h0);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        do_reset();
        rw(0, 16'h2100, 0);
        chk(q, 32'h2);
        rw(0, 16'h2101, 0);
        chk(q, 32'h1);
        rw(1, 16'h1a01, 32'h0);
        rw(0, 16'h1a01, 0);
        chk(q, 32'h60040020);
        // Refused mapping write shows in status until cleared
        rw(0, 16'h2181, 0);
        chk(q, 32'h00040102);
        rw(1, 16'h2181, 32'h000c0000);
        rw(0, 16'h2181, 0);
        chk(q, 32'h00000102);
        rw(1, 16'h0123, 32'hff);
        rw(0, 16'h0123, 0);
        chk(q, 32'h0);
        // Boundary values first, then random ones
        for (i = 0; i < 16; i++) begin
            c = (i < 4) ? rb[i] : (rnd() & 32'hf);
            rw(1, 16'h2100, c);
            if (c <= 32'h8) w_rate = c;
            rw(0, 16'h2100, 0);
            chk(q, w_rate);
            c = (i < 4) ? nb[i] : (rnd() & 32'hff);
            rw(1, 16'h2101, c);
            if (c >= 32'h1 && c <= 32'h7f) w_node = c;
            rw(0, 16'h2101, 0);
            chk(q, w_node);
        end
        // Range refusal is sticky; pending follows the working values
        c = (w_rate != 32'h2 || w_node != 32'h1) ? 32'h000a0102
            : 32'h00080102;
        rw(0, 16'h2181, 0);
        chk(q, c);
        // Every code through store and reinit
        for (i = 0; i < 9; i++) begin
            rw(1, 16'h2100, i);
            w_rate = i;
            rw(1, 16'h2180, 32'h1);
            wait_busy(1'b1, 5);
            wait_busy(1'b0, 300);
            {s_rate, s_node} = {w_rate, w_node};
            @(posedge mclk);
            chk(bit_rate_code, r_rate);
            chk(config_pending, s_rate != r_rate || s_node != r_node);
            rw(1, 16'h2180, 32'h2);
            {r_rate, r_node} = {s_rate, s_node};
            @(posedge mclk);
            chk(bit_rate_code, r_rate);
            chk(bit_rate_kbps, tab[i]);
            chk(node_identifier, r_node);
            chk(config_pending, 32'h0);
        end
        // Reinit without store brings back the stored image
        rw(1, 16'h2100, 32'h3);
        rw(1, 16'h2180, 32'h2);
        rw(0, 16'h2100, 0);
        chk(q, s_rate);
        chk(bit_rate_code, s_rate);
        do_reset();
        test_done();
    end
endmodule

bind can_node_config_objects can_cfg_properties chk_i (.mclk(mclk),
    .reset(reset), .av_req(av_req), .av_rsp(av_rsp),
    .bit_rate_code(bit_rate_code), .bit_rate_kbps(bit_rate_kbps),
    .node_identifier(node_identifier), .store_busy(store_busy),
    .config_pending(config_pending));
